/* rtl/pvcs_pkg.sv */
// pvcs_pkg: constants, register map and carrier types of the vco calibration sequencer
// assumes one clock domain; registers are 8-bit, byte addressed, 64 locations
package pvcs_pkg;
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam logic [5:0]  ADDR_INT_LO     = 6'h10;
  localparam logic [5:0]  ADDR_INT_HI     = 6'h11;
  localparam logic [5:0]  ADDR_PRIMARY_FRACTION_0    = 6'h14;
  localparam logic [5:0]  ADDR_PRIMARY_FRACTION_1    = 6'h15;
  localparam logic [5:0]  ADDR_PRIMARY_FRACTION_2    = 6'h16;
  localparam logic [5:0]  ADDR_PRIMARY_FRACTION_3    = 6'h17;
  localparam logic [5:0]  ADDR_AUXILIARY_FRACTION_LO   = 6'h18;
  localparam logic [5:0]  ADDR_AUXILIARY_FRACTION_HI   = 6'h19;
  localparam logic [5:0]  ADDR_AUXILIARY_MODULUS_LO    = 6'h1A;
  localparam logic [5:0]  ADDR_AUXILIARY_MODULUS_HI    = 6'h1B;
  localparam logic [5:0]  ADDR_OUTDIV     = 6'h1D;
  localparam logic [5:0]  ADDR_PUMP       = 6'h1E;
  localparam logic [5:0]  ADDR_REFCTL     = 6'h1F;
  localparam logic [5:0]  ADDR_BAND_DIV   = 6'h30;
  localparam logic [5:0]  ADDR_FINE_LO    = 6'h31;
  localparam logic [5:0]  ADDR_FINE_HI    = 6'h32;
  localparam logic [5:0]  ADDR_DAC_COARSE = 6'h33;
  localparam logic [5:0]  ADDR_LVL_COARSE = 6'h34;
  localparam logic [5:0]  ADDR_STATUS     = 6'h35;
  // refctl fields
  localparam int unsigned REFCTL_DOUBLER  = 0;
  localparam int unsigned REFCTL_HALVING  = 1;
  localparam int unsigned REFCTL_RDIV_LSB = 2;
  localparam int unsigned REFCTL_AUTOCAL  = 7;
  // reset values
  localparam logic [7:0]  RST_BAND_DIV    = 8'h01;
  localparam logic [7:0]  RST_FINE_LO     = 8'h02;
  localparam logic [7:0]  RST_DAC_COARSE  = 8'h02;
  localparam logic [7:0]  RST_LVL_COARSE  = 8'h03;
  localparam logic [7:0]  RST_REFCTL      = 8'h84;
  localparam logic [7:0]  RST_AUXILIARY_MODULUS_LO     = 8'h02;
  // sequence counts
  localparam logic [10:0] COARSE_SCALE    = 11'h400;
  localparam logic [3:0]  BAND_STEP_CYC   = 4'hF;
  localparam logic [3:0]  BAND_STEPS      = 4'hB;
  localparam logic [5:0]  LEVEL_STEPS     = 6'h3F;
  localparam logic [5:0]  RDIV_MAX        = 6'h20;
  localparam int unsigned PRIMARY_MOD_BITS = 25;

  typedef enum logic [2:0] {
    PVCS_IDLE, PVCS_DAC_SETTLE, PVCS_BAND, PVCS_LEVEL, PVCS_LOOP
  } pvcs_state_e;

  // active (double-buffered) frequency setting
  typedef struct packed {
    logic [15:0]                 int_value;
    logic [PRIMARY_MOD_BITS-1:0] primary_fraction;
    logic [13:0]                 auxiliary_fraction;
    logic [13:0]                 auxiliary_modulus;
    logic                        doubler;
    logic                        reference_halving;
    logic [4:0]                  ref_div;
    logic [3:0]                  pump_current;
    logic [2:0]                  out_div_sel;
  } pvcs_cfg_s;

  typedef struct packed {
    logic       dac_force;
    logic       band_active;
    logic       level_active;
    logic       loop_closed;
    logic       cal_done;
    logic [3:0] band_step;
    logic [5:0] bias_step;
  } pvcs_cal_s;
endpackage : pvcs_pkg

/* rtl/pvcs_top.sv */
// pvcs_top: reference path, double-buffered frequency setting and vco calibration sequencer
// assumes clk is the oversampled reference (one reference edge per two clk cycles) and a simple
// synchronous byte register port driven by the serial front end
// Notes on behaviour
// - settle, band select, level cal, then loop
// - dac forces tune voltage during settle wait
// - settle wait is coarse*1024+fine phase ticks
// - band clock is phase clock over divider
// - eleven band steps of sixteen band clocks
// - level calibration picks core bias current
// - level step waits level*1024+fine ticks
// - level calibration runs 63 steps
// - phase rate is ref*(1+D)/(R*(1+T))
// - doubler doubles the reference rate
// - halving divides by two, 50% duty
// - feedback ratio from int, fractions, moduli
// - output is vco over output divider
// - integer write starts calibration when enabled
// - buffered settings apply on integer write
// - reference divider covers 1 to 32
// - loop reconnects when level calibration starts
`timescale 1ns/10ps
module pvcs_top
  import pvcs_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // register port
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [5:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  output logic      [7:0]        reg_rdata,
  // phase detector clock
  output logic                   pfd_clk,
  // active frequency setting and calibration controls
  output pvcs_pkg::pvcs_cfg_s    freq_cfg,
  output logic      [6:0]        rf_div_ratio,
  output pvcs_pkg::pvcs_cal_s    cal
);
  import pvcs_pkg::*;

  logic [7:0]  shadow_reg [0:63];
  pvcs_state_e state_reg;
  logic        ref_phase_reg;
  logic [5:0]  r_cnt_reg;
  logic        half_reg;
  logic [14:0] wait_cnt_reg;
  logic [7:0]  bdiv_cnt_reg;
  logic [3:0]  cyc_cnt_reg;
  logic [3:0]  band_step_reg;
  logic [5:0]  bias_step_reg;
  logic        done_reg;
  logic        int_write;
  logic        ref_tick;
  logic        r_wrap;
  logic        pfd_tick;
  logic        bsc_tick;
  logic        wait_zero;
  logic [5:0]  r_ratio;
  logic [7:0]  band_div;

  function automatic logic [14:0] settle_target(input logic [7:0] coarse);
    logic [25:0] sum;
    sum = 26'(coarse[4:0]) * 26'(COARSE_SCALE) + 26'({shadow_reg[ADDR_FINE_HI][1:0], shadow_reg[ADDR_FINE_LO]});
    settle_target = 15'(sum - 26'd1);
  endfunction : settle_target

  assign int_write = reg_wr && (reg_addr == ADDR_INT_LO);

  // register storage and read answer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 64; i++) begin
        shadow_reg[i] <= 8'h00;
      end
      shadow_reg[ADDR_BAND_DIV]   <= RST_BAND_DIV;
      shadow_reg[ADDR_FINE_LO]    <= RST_FINE_LO;
      shadow_reg[ADDR_DAC_COARSE] <= RST_DAC_COARSE;
      shadow_reg[ADDR_LVL_COARSE] <= RST_LVL_COARSE;
      shadow_reg[ADDR_REFCTL]     <= RST_REFCTL;
      shadow_reg[ADDR_AUXILIARY_MODULUS_LO]    <= RST_AUXILIARY_MODULUS_LO;
    end else if (reg_wr && reg_addr != ADDR_STATUS) begin
      shadow_reg[reg_addr] <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ADDR_STATUS: reg_rdata <= {done_reg, band_step_reg == BAND_STEPS, 3'h0, 3'(state_reg)};
        ADDR_INT_LO, ADDR_INT_HI, ADDR_PRIMARY_FRACTION_0, ADDR_PRIMARY_FRACTION_1, ADDR_PRIMARY_FRACTION_2, ADDR_PRIMARY_FRACTION_3,
        ADDR_AUXILIARY_FRACTION_LO, ADDR_AUXILIARY_FRACTION_HI, ADDR_AUXILIARY_MODULUS_LO, ADDR_AUXILIARY_MODULUS_HI, ADDR_OUTDIV, ADDR_PUMP,
        ADDR_REFCTL, ADDR_BAND_DIV, ADDR_FINE_LO, ADDR_FINE_HI, ADDR_DAC_COARSE,
        ADDR_LVL_COARSE: reg_rdata <= shadow_reg[reg_addr];
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // buffered values move to the active set only on the integer write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      freq_cfg     <= '0;
      rf_div_ratio <= 7'h01;
    end else if (int_write) begin
      freq_cfg.int_value          <= {shadow_reg[ADDR_INT_HI], reg_wdata};
      freq_cfg.primary_fraction   <= {shadow_reg[ADDR_PRIMARY_FRACTION_3][0], shadow_reg[ADDR_PRIMARY_FRACTION_2],
                                      shadow_reg[ADDR_PRIMARY_FRACTION_1], shadow_reg[ADDR_PRIMARY_FRACTION_0]};
      freq_cfg.auxiliary_fraction <= {shadow_reg[ADDR_AUXILIARY_FRACTION_HI][5:0], shadow_reg[ADDR_AUXILIARY_FRACTION_LO]};
      freq_cfg.auxiliary_modulus  <= {shadow_reg[ADDR_AUXILIARY_MODULUS_HI][5:0], shadow_reg[ADDR_AUXILIARY_MODULUS_LO]};
      freq_cfg.doubler            <= shadow_reg[ADDR_REFCTL][REFCTL_DOUBLER];
      freq_cfg.reference_halving  <= shadow_reg[ADDR_REFCTL][REFCTL_HALVING];
      freq_cfg.ref_div            <= shadow_reg[ADDR_REFCTL][REFCTL_RDIV_LSB +: 5];
      freq_cfg.pump_current       <= shadow_reg[ADDR_PUMP][3:0];
      freq_cfg.out_div_sel        <= shadow_reg[ADDR_OUTDIV][2:0];
      // selects above 6 clamp to divide by 64
      rf_div_ratio <= (shadow_reg[ADDR_OUTDIV][2:0] > 3'h6) ? 7'h40 : 7'(7'h01 << shadow_reg[ADDR_OUTDIV][2:0]);
    end
  end

  // reference path: doubler, divider by R, optional halving
  assign ref_tick = freq_cfg.doubler | ref_phase_reg;
  assign r_ratio  = (freq_cfg.ref_div == 5'h00) ? RDIV_MAX : {1'b0, freq_cfg.ref_div};
  assign r_wrap   = ref_tick && (r_cnt_reg == r_ratio - 6'h01);
  assign pfd_tick = r_wrap && (!freq_cfg.reference_halving || !half_reg);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_phase_reg <= 1'b0;
      r_cnt_reg     <= 6'h00;
      half_reg      <= 1'b0;
      pfd_clk       <= 1'b0;
    end else begin
      ref_phase_reg <= ~ref_phase_reg;
      if (int_write) begin
        r_cnt_reg <= 6'h00;
      end else if (r_wrap) begin
        r_cnt_reg <= 6'h00;
      end else if (ref_tick) begin
        r_cnt_reg <= r_cnt_reg + 6'h01;
      end
      if (r_wrap) begin
        half_reg <= ~half_reg;
      end
      // toggle gives even duty; without halving the clock is a one-cycle pulse
      pfd_clk <= freq_cfg.reference_halving ? (r_wrap ? ~half_reg : half_reg) : r_wrap;
    end
  end

  // band-selection clock enable
  assign band_div = (shadow_reg[ADDR_BAND_DIV] == 8'h00) ? 8'h01 : shadow_reg[ADDR_BAND_DIV];
  assign bsc_tick = pfd_tick && (bdiv_cnt_reg == band_div - 8'h01);
  assign wait_zero = (wait_cnt_reg == 15'h0000);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bdiv_cnt_reg <= 8'h00;
    end else if (state_reg != PVCS_BAND || bsc_tick) begin
      bdiv_cnt_reg <= 8'h00;
    end else if (pfd_tick) begin
      bdiv_cnt_reg <= bdiv_cnt_reg + 8'h01;
    end
  end

  // calibration sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg     <= PVCS_IDLE;
      wait_cnt_reg  <= 15'h0000;
      cyc_cnt_reg   <= 4'h0;
      band_step_reg <= 4'h0;
      bias_step_reg <= 6'h00;
    end else if (int_write && shadow_reg[ADDR_REFCTL][REFCTL_AUTOCAL]) begin
      // a new integer write restarts any calibration in flight
      state_reg     <= PVCS_DAC_SETTLE;
      wait_cnt_reg  <= settle_target(shadow_reg[ADDR_DAC_COARSE]);
      cyc_cnt_reg   <= 4'h0;
      band_step_reg <= 4'h0;
      bias_step_reg <= 6'h00;
    end else begin
      unique case (state_reg)
        PVCS_IDLE, PVCS_LOOP: begin
        end
        PVCS_DAC_SETTLE: begin
          if (pfd_tick) begin
            if (wait_zero) begin
              state_reg <= PVCS_BAND;
            end else begin
              wait_cnt_reg <= wait_cnt_reg - 15'h0001;
            end
          end
        end
        PVCS_BAND: begin
          if (bsc_tick) begin
            cyc_cnt_reg <= cyc_cnt_reg + 4'h1;
            if (cyc_cnt_reg == BAND_STEP_CYC) begin
              band_step_reg <= band_step_reg + 4'h1;
              if (band_step_reg == BAND_STEPS - 4'h1) begin
                state_reg    <= PVCS_LEVEL;
                wait_cnt_reg <= settle_target(shadow_reg[ADDR_LVL_COARSE]);
              end
            end
          end
        end
        PVCS_LEVEL: begin
          if (pfd_tick) begin
            if (!wait_zero) begin
              wait_cnt_reg <= wait_cnt_reg - 15'h0001;
            end else begin
              bias_step_reg <= bias_step_reg + 6'h01;
              wait_cnt_reg  <= settle_target(shadow_reg[ADDR_LVL_COARSE]);
              if (bias_step_reg == LEVEL_STEPS - 6'h01) begin
                state_reg <= PVCS_LOOP;
              end
            end
          end
        end
        default: state_reg <= PVCS_IDLE;
      endcase
    end
  end

  // done stays set until the next calibration start
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done_reg <= 1'b0;
    end else if (state_reg == PVCS_LEVEL && pfd_tick && wait_zero && bias_step_reg == LEVEL_STEPS - 6'h01) begin
      done_reg <= 1'b1;
    end else if (int_write && shadow_reg[ADDR_REFCTL][REFCTL_AUTOCAL]) begin
      done_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cal <= '0;
    end else begin
      cal.dac_force    <= (state_reg == PVCS_DAC_SETTLE) || (state_reg == PVCS_BAND);
      cal.band_active  <= (state_reg == PVCS_BAND);
      cal.level_active <= (state_reg == PVCS_LEVEL);
      cal.loop_closed  <= (state_reg == PVCS_IDLE) || (state_reg == PVCS_LOOP) || (state_reg == PVCS_LEVEL);
      cal.cal_done     <= done_reg;
      cal.band_step    <= band_step_reg;
      cal.bias_step    <= bias_step_reg;
    end
  end
endmodule : pvcs_top

/* dv/pvcs_checker.sv */
// pvcs_checker: port-level timing checks of the calibration sequencer
// assumes one clock domain and the async active-low reset of pvcs_top
`timescale 1ns/10ps
module pvcs_checker
  import pvcs_pkg::*;
(
  // watched ports
  input wire logic                clk,
  input wire logic                rst_n,
  input wire logic                reg_wr,
  input wire logic [5:0]          reg_addr,
  input wire pvcs_pkg::pvcs_cfg_s freq_cfg,
  input wire logic [6:0]          rf_div_ratio,
  input wire pvcs_pkg::pvcs_cal_s cal
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  logic [6:0] div_exp;
  logic       int_wr;
  assign div_exp = (freq_cfg.out_div_sel > 3'h6) ? 7'h40 : 7'h01 << freq_cfg.out_div_sel;
  assign int_wr  = reg_wr && reg_addr == ADDR_INT_LO;
  property p_band_forced; cal.band_active |-> cal.dac_force; endproperty
  a_band_forced: assert property (p_band_forced) else $error("band search with tune released");
  property p_order; $rose(cal.band_active) |-> $past(cal.dac_force); endproperty
  a_order: assert property (p_order) else $error("band search without settle");
  property p_band_end; $rose(cal.level_active) |-> $past(cal.band_active) && cal.band_step == BAND_STEPS; endproperty
  a_band_end: assert property (p_band_end) else $error("level start before band end");
  property p_level_loop; cal.level_active |-> cal.loop_closed && !cal.dac_force; endproperty
  a_level_loop: assert property (p_level_loop) else $error("loop open in level phase");
  property p_done; $rose(cal.cal_done) |-> $past(cal.level_active) && cal.bias_step == LEVEL_STEPS; endproperty
  a_done: assert property (p_done) else $error("done without full level phase");
  property p_done_hold; cal.cal_done && !int_wr && !$past(int_wr) |=> cal.cal_done; endproperty
  a_done_hold: assert property (p_done_hold) else $error("done dropped without restart");
  property p_start; $rose(cal.dac_force) |-> $past(int_wr, 2); endproperty
  a_start: assert property (p_start) else $error("sequence start without integer write");
  property p_buffer; !$stable(freq_cfg) |-> $past(int_wr); endproperty
  a_buffer: assert property (p_buffer) else $error("setting moved without integer write");
  property p_div; rf_div_ratio == div_exp; endproperty
  a_div: assert property (p_div) else $error("output divider ratio wrong");
endmodule : pvcs_checker
bind pvcs_top pvcs_checker chk_u (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_addr(reg_addr),
  .freq_cfg(freq_cfg), .rf_div_ratio(rf_div_ratio), .cal(cal));

/* dv/pvcs_top_tb.sv */
// pvcs_top_tb: self-checking bench of the calibration sequencer
// assumes pvcs_top with bound checker; bench drives the register port itself
`timescale 1ns/10ps
module pvcs_top_tb;
  import pvcs_pkg::*;
  logic       clk        = 1'b0;
  logic       rst_n      = 1'b0;
  logic       reg_wr     = 1'b0;
  logic       reg_rd     = 1'b0;
  logic [5:0] reg_addr   = 6'h00;
  logic [7:0] reg_wdata  = 8'h00;
  logic [7:0] reg_rdata;
  logic       pfd_clk;
  pvcs_cfg_s  freq_cfg;
  logic [6:0] rf_div_ratio;
  pvcs_cal_s  cal;
  int         fail_count = 0;
  int         num_checks = 0;
  always #50 clk = ~clk;
  pvcs_top dut_u (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pfd_clk(pfd_clk), .freq_cfg(freq_cfg),
    .rf_div_ratio(rf_div_ratio), .cal(cal));
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("BAD %s expected %0h seen %0h", what, exp, got);
      fail_count++;
    end
  endtask : chk
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk) #1 reg_wr = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(posedge clk) #1 reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    @(posedge clk) #1 reg_rd = 1'b1;
    reg_addr = a;
    @(posedge clk) #1 reg_rd = 1'b0;
    chk($sformatf("reg %0h", a), e, reg_rdata);
  endtask : rd
  function automatic int pfd_period(input int r, input int d, input int t);
    return 2 * r * (1 + t) / (1 + d);
  endfunction : pfd_period
  function automatic logic [6:0] div_of(input logic [2:0] s);
    return (s > 3'h6) ? 7'h40 : 7'h01 << s;
  endfunction : div_of
  // window of four whole periods: edge and high counts are then exact
  task automatic pfd_run(input int r, input int d, input int t);
    int   p, n, hi;
    logic prev;
    wr(ADDR_REFCTL, {1'b0, r[4:0], t[0], d[0]});
    wr(ADDR_INT_LO, 8'h40);
    p = pfd_period((r == 0) ? 32 : r, d, t);
    n = 0;
    hi = 0;
    repeat (p) @(posedge clk);
    #1 prev = pfd_clk;
    repeat (4 * p) begin
      @(posedge clk) #1 hi += pfd_clk;
      n += (pfd_clk && !prev);
      prev = pfd_clk;
    end
    chk("pfd edges", 4, n);
    chk("pfd high", (t == 1) ? 2 * p : 4, hi);
  endtask : pfd_run
  // phase tick equals clk here, so phase lengths are counted in cycles
  task automatic cal_run(input logic [7:0] coarse, input logic [7:0] bd, input logic [7:0] fine);
    int i, s, b, l;
    wr(ADDR_BAND_DIV, bd);
    wr(ADDR_FINE_LO, fine);
    wr(ADDR_DAC_COARSE, coarse);
    wr(ADDR_INT_LO, 8'h44);
    s = 0;
    b = 0;
    l = 0;
    for (i = 0; i < 20000 && (i == 0 || cal.cal_done !== 1'b1); i++) begin
      @(posedge clk) #1 s += cal.dac_force & !cal.band_active;
      if (i == 0) chk("start", 2'b10, {cal.dac_force, cal.cal_done});
      b += cal.band_active;
      l += cal.level_active;
    end
    if (i == 20000) begin
      $display("BAD calibration expected done seen timeout");
      fail_count++;
      wrap_up();
    end
    chk("settle", coarse * 1024 + fine, s);
    chk("band len", 1, b >= 175 * bd && b <= 177 * bd);
    chk("level len", 1, l >= 63 * fine && l <= 63 * (fine + 1));
    chk("bias", LEVEL_STEPS, cal.bias_step);
    chk("band", BAND_STEPS, cal.band_step);
    chk("loop", 1, cal.loop_closed);
    rd(ADDR_STATUS, 8'hC4);
  endtask : cal_run
  initial begin
    logic [7:0] v;
    logic [7:0] pv;
    void'($urandom(40));
    repeat (5) @(posedge clk);
    #1 rst_n = 1'b1;
    chk("cfg reset", 0, freq_cfg);
    chk("div reset", 1, rf_div_ratio);
    rd(ADDR_BAND_DIV, RST_BAND_DIV);
    rd(ADDR_FINE_LO, RST_FINE_LO);
    rd(ADDR_DAC_COARSE, RST_DAC_COARSE);
    rd(ADDR_LVL_COARSE, RST_LVL_COARSE);
    rd(ADDR_REFCTL, RST_REFCTL);
    wr(ADDR_STATUS, 8'hFF);
    rd(ADDR_STATUS, 8'h00);
    rd(6'h3F, 8'h00);
    v = 8'($urandom);
    wr(ADDR_BAND_DIV, v);
    rd(ADDR_BAND_DIV, v);
    $display("test registers done");
    // autocal off: integer writes only latch the buffered setting
    wr(ADDR_REFCTL, 8'h04);
    pv = 8'h00;
    for (int s = 0; s < 8; s++) begin
      v = 8'($urandom);
      wr(ADDR_OUTDIV, 8'(s));
      wr(ADDR_PRIMARY_FRACTION_0, v);
      wr(ADDR_AUXILIARY_FRACTION_LO, v);
      wr(ADDR_AUXILIARY_MODULUS_LO, v);
      wr(ADDR_PUMP, v);
      chk("held", pv, freq_cfg.primary_fraction[7:0]);
      chk("held aux frac", pv, freq_cfg.auxiliary_fraction[7:0]);
      chk("held aux mod", pv, freq_cfg.auxiliary_modulus[7:0]);
      chk("held pump", pv[3:0], freq_cfg.pump_current);
      wr(ADDR_INT_LO, v ^ 8'h5A);
      chk("frac", v, freq_cfg.primary_fraction[7:0]);
      chk("aux frac", v, freq_cfg.auxiliary_fraction[7:0]);
      chk("aux mod", v, freq_cfg.auxiliary_modulus[7:0]);
      chk("pump", v[3:0], freq_cfg.pump_current);
      chk("int", v ^ 8'h5A, freq_cfg.int_value[7:0]);
      chk("ratio", div_of(3'(s)), rf_div_ratio);
      pv = v;
    end
    chk("no cal", 0, cal.dac_force);
    $display("test buffering done");
    pfd_run(0, 0, 1);
    pfd_run(2, 1, 0);
    repeat (6) pfd_run(2 + $urandom % 7, $urandom % 2, $urandom % 2);
    $display("test phase clock done");
    // level coarse 0 breaks on purpose: a legal count makes 63 steps of at least 1024 cycles
    wr(ADDR_FINE_HI, 8'h00);
    wr(ADDR_LVL_COARSE, 8'h00);
    wr(ADDR_REFCTL, 8'h85);
    // phase ticks run at 10 MHz here, so a band divider of 5 or more keeps the band clock legal
    cal_run(8'h02, 8'h05, 8'h02);
    wr(ADDR_INT_LO, 8'h44);
    repeat (30) @(posedge clk);
    cal_run(8'(2 + $urandom % 2), 8'(5 + $urandom % 4), 8'(3 + $urandom % 20));
    $display("test calibration done");
    wrap_up();
  end
endmodule : pvcs_top_tb
